// ==== src/ftc_pkg.sv ====
// Constants shared by the flash/torch mode control block.
// Assumes a 20 MHz internal oscillator clock and 32-bit APB data.
package ftc_pkg;

    // Clock rate and documented times in their own units
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned TIMEOUT_MS    = 1000;   // Flash held longer than this trips
    localparam int unsigned TORCH_STEP_MS = 125;    // Gain step time in torch mode
    localparam int unsigned FLASH_STEP_MS = 2;      // Gain step time in flash mode

    // Derived cycle counts
    localparam int unsigned TIMEOUT_CYC    = TIMEOUT_MS * CYC_PER_MS;
    localparam int unsigned TORCH_STEP_CYC = TORCH_STEP_MS * CYC_PER_MS;
    localparam int unsigned FLASH_STEP_CYC = FLASH_STEP_MS * CYC_PER_MS;
    localparam int          CNT_W          = 25;

    // Register map (byte addresses)
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_STATUS = 8'h04;
    localparam logic [7:0]  REG_TOCNT  = 8'h08;

    // Control register: soft-start cycles per reference step, less one
    localparam int          SS_DIV_W   = 16;
    localparam logic [15:0] SS_DIV_RST = 16'h0014;

    // Status register field positions
    localparam int ST_EN_BIT    = 0;
    localparam int ST_RUN_BIT   = 1;
    localparam int ST_TO_BIT    = 2;
    localparam int ST_FLASH_BIT = 3;
    localparam int ST_GAIN_LSB  = 4;
    localparam int ST_REF_LSB   = 8;
    localparam int ST_SINK_LSB  = 16;

    // Charge-pump gain codes, ordered so that higher means more gain
    localparam logic [1:0] GAIN_1X  = 2'h0;
    localparam logic [1:0] GAIN_15X = 2'h1;
    localparam logic [1:0] GAIN_2X  = 2'h2;

    // Sink enable patterns
    localparam logic [3:0] SINKS_ALL   = 4'hF;
    localparam logic [3:0] SINKS_THREE = 4'h7;
    localparam logic [3:0] SINKS_NONE  = 4'h0;

    // Soft-start reference ramp
    localparam int         REF_W   = 8;
    localparam logic [7:0] REF_MAX = 8'hFF;

    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // Operating states
    typedef enum logic [1:0] {FTC_OFF, FTC_START, FTC_RUN, FTC_TIMEOUT} ftc_state_t;

endpackage

// ==== src/ftc_sync.sv ====
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none
module ftc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ftc_sync_t;

    ftc_sync_t r, n;

    // First stage is read only by the second stage
    always_comb
    begin
        n      = r;
        n.meta = d_i;
        n.sync = r.meta;
    end

    // Both stages clear to low, like an undriven pulled-down pin
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            r <= '0;
        else
            r <= n;
    end

    assign q_o = r.sync;
endmodule
`default_nettype wire

// ==== src/ftc_ctrl.sv ====
// Flash/torch mode control: pin decode, soft start, flash timeout, gain stepping, APB regs.
// Assumes async control pins and analog status levels, 20 MHz clock, APB master on MCLK_I.
`timescale 1ns/1ps
`default_nettype none
module ftc_ctrl
    import ftc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES    = TIMEOUT_CYC,
    parameter int unsigned TORCH_STEP_CYCLES = TORCH_STEP_CYC,
    parameter int unsigned FLASH_STEP_CYCLES = FLASH_STEP_CYC
) (
    // Clock and reset
    input  wire logic              MCLK_I,
    input  wire logic              RESETN_I,
    // Control pins
    input  wire logic              EN_I,
    input  wire logic              TORCH_FLASH_I,
    input  wire logic              TX_OVERRIDE_I,
    input  wire logic              SINK_SEL_I,
    // Analog status
    input  wire logic              VOUT_OK_I,
    input  wire logic              GAIN_UP_REQ_I,
    // APB slave
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    input  wire logic [3:0]        PSTRB_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    // Analog control
    output logic                   PUMP_EN_O,
    output logic                   OUT_CONNECT_O,
    output logic      [REF_W-1:0]  REF_LEVEL_O,
    output logic      [1:0]        GAIN_O,
    output logic      [3:0]        SINK_EN_O,
    output logic                   FLASH_LEVEL_O,
    output logic                   TIMEOUT_O
);
    // Refuse counts that do not fit the counters
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << CNT_W))
        $error("TIMEOUT_CYCLES out of range");
    if (TORCH_STEP_CYCLES < 1 || TORCH_STEP_CYCLES >= (1 << CNT_W))
        $error("TORCH_STEP_CYCLES out of range");
    if (FLASH_STEP_CYCLES < 1 || FLASH_STEP_CYCLES >= (1 << CNT_W))
        $error("FLASH_STEP_CYCLES out of range");

    typedef struct packed {
        ftc_state_t           state;
        logic                 pump;
        logic                 to_flag;
        logic [CNT_W-1:0]     to_cnt;
        logic [CNT_W-1:0]     step_cnt;
        logic [1:0]           gain;
        logic [REF_W-1:0]     ss_ref;
        logic [SS_DIV_W-1:0]  ss_div;
        logic [SS_DIV_W-1:0]  cfg_ss_div;
        logic [3:0]           sink_en;
        logic                 flash_lvl;
        logic [31:0]          prdata;
        logic                 pslverr;
    } ftc_regs_t;

    ftc_regs_t r, n;

    logic [5:0]       pins_s;
    logic             en_s;
    logic             tf_s;
    logic             tx_s;
    logic             sel_s;
    logic             vok_s;
    logic             gup_s;
    logic             to_hit;
    logic [CNT_W-1:0] step_lim;
    logic [31:0]      status_w;
    logic [31:0]      rdata_w;
    logic             mapped_w;
    logic             wr_ctrl;

    // Pins and analog levels cross into the oscillator domain
    ftc_sync #(
        .W (6)
    ) u_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RESETN_I),
        .d_i     ({GAIN_UP_REQ_I, VOUT_OK_I, SINK_SEL_I, TX_OVERRIDE_I, TORCH_FLASH_I, EN_I}),
        .q_o     (pins_s)
    );

    // Active-high decode of the synchronised pins
    assign en_s  = pins_s[0];
    assign tf_s  = pins_s[1];
    assign tx_s  = pins_s[2];
    assign sel_s = pins_s[3];
    assign vok_s = pins_s[4];
    assign gup_s = pins_s[5];

    // Flash held past the limit with no override active
    assign to_hit = tf_s && !tx_s && (r.to_cnt == CNT_W'(TIMEOUT_CYCLES - 1));

    // Gain step interval follows the present current level
    assign step_lim = r.flash_lvl ? CNT_W'(FLASH_STEP_CYCLES - 1)
                                  : CNT_W'(TORCH_STEP_CYCLES - 1);

    // Status word and read mux
    always_comb
    begin
        status_w                            = DATA_ZERO;
        status_w[ST_EN_BIT]                 = r.pump;
        status_w[ST_RUN_BIT]                = (r.state == FTC_RUN);
        status_w[ST_TO_BIT]                 = r.to_flag;
        status_w[ST_FLASH_BIT]              = r.flash_lvl;
        status_w[ST_GAIN_LSB +: 2]          = r.gain;
        status_w[ST_REF_LSB +: REF_W]       = r.ss_ref;
        status_w[ST_SINK_LSB +: 4]          = r.sink_en;
        rdata_w  = DATA_ZERO;
        mapped_w = 1'b1;
        case (PADDR_I)
            REG_CTRL:   rdata_w[SS_DIV_W-1:0] = r.cfg_ss_div;
            REG_STATUS: rdata_w = status_w;
            REG_TOCNT:  rdata_w[CNT_W-1:0] = r.to_cnt;
            default:    mapped_w = 1'b0;
        endcase
    end

    assign wr_ctrl = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == REG_CTRL);

    // Next-state logic
    always_comb
    begin
        n = r;

        // Mode sequencing
        case (r.state)
            FTC_OFF:
            begin
                n.state = FTC_START;
            end
            FTC_START:
            begin
                if (to_hit)
                    n.state = FTC_TIMEOUT;
                else if (vok_s && r.ss_ref == REF_MAX)
                    n.state = FTC_RUN;
            end
            FTC_RUN:
            begin
                if (to_hit)
                    n.state = FTC_TIMEOUT;
            end
            FTC_TIMEOUT:
            begin
                n.state = FTC_TIMEOUT;
            end
            default:
            begin
                n.state = FTC_OFF;
            end
        endcase
        if (!en_s)
            n.state = FTC_OFF;

        // Pump and output switch follow enable, also during timeout
        n.pump    = en_s;
        n.to_flag = (n.state == FTC_TIMEOUT);

        // Flash timeout counter
        if (!en_s || !tf_s || r.state == FTC_TIMEOUT)
            n.to_cnt = '0;
        else if (tx_s)
            n.to_cnt = r.to_cnt;
        else if (!to_hit)
            n.to_cnt = r.to_cnt + CNT_W'(1);

        // Soft-start reference ramp, held at zero until the pump is on
        if (!en_s)
        begin
            n.ss_ref = '0;
            n.ss_div = '0;
        end
        else if (r.pump && r.ss_ref != REF_MAX)
        begin
            if (r.ss_div >= r.cfg_ss_div)
            begin
                n.ss_div = '0;
                n.ss_ref = r.ss_ref + REF_W'(1);
            end
            else
                n.ss_div = r.ss_div + SS_DIV_W'(1);
        end

        // Upward-only gain stepping; a level change restarts the interval
        if (!en_s)
        begin
            n.gain     = GAIN_1X;
            n.step_cnt = '0;
        end
        else if (gup_s && r.state == FTC_RUN && r.gain != GAIN_2X
                 && r.flash_lvl == (tf_s && !tx_s))
        begin
            if (r.step_cnt == step_lim)
            begin
                n.step_cnt = '0;
                n.gain     = r.gain + 2'h1;
            end
            else
                n.step_cnt = r.step_cnt + CNT_W'(1);
        end
        else
            n.step_cnt = '0;

        // Current level and sink selection
        n.flash_lvl = en_s && tf_s && !tx_s;
        if (n.state == FTC_RUN)
            n.sink_en = sel_s ? SINKS_THREE : SINKS_ALL;
        else
            n.sink_en = SINKS_NONE;

        // APB: read data latched in setup, write in access
        if (PSEL_I && !PENABLE_I)
        begin
            n.prdata  = PWRITE_I ? DATA_ZERO : rdata_w;
            n.pslverr = !mapped_w;
        end
        if (wr_ctrl)
        begin
            if (PSTRB_I[0])
                n.cfg_ss_div[7:0] = PWDATA_I[7:0];
            if (PSTRB_I[1])
                n.cfg_ss_div[15:8] = PWDATA_I[15:8];
        end
    end

    // State register
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            r            <= '0;
            r.state      <= FTC_OFF;
            r.gain       <= GAIN_1X;
            r.cfg_ss_div <= SS_DIV_RST;
        end
        else
            r <= n;
    end

    // Outputs
    assign PRDATA_O      = r.prdata;
    assign PREADY_O      = 1'b1;
    assign PSLVERR_O     = PSEL_I && PENABLE_I && r.pslverr;
    assign PUMP_EN_O     = r.pump;
    assign OUT_CONNECT_O = r.pump;
    assign REF_LEVEL_O   = r.ss_ref;
    assign GAIN_O        = r.gain;
    assign SINK_EN_O     = r.sink_en;
    assign FLASH_LEVEL_O = r.flash_lvl;
    assign TIMEOUT_O     = r.to_flag;

    // Checks
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESETN_I);

    property p_shutdown;
        !en_s |=> (r.state == FTC_OFF) && (SINK_EN_O == SINKS_NONE) && !PUMP_EN_O;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("not shut down");

    property p_torch;
        !tf_s |=> !FLASH_LEVEL_O;
    endproperty
    a_torch: assert property (p_torch) else $error("flash level in torch");

    property p_flash;
        en_s && tf_s && !tx_s |=> FLASH_LEVEL_O;
    endproperty
    a_flash: assert property (p_flash) else $error("flash level missing");

    property p_tx_reduce;
        tf_s && tx_s |=> !FLASH_LEVEL_O;
    endproperty
    a_tx_reduce: assert property (p_tx_reduce) else $error("override ignored");

    property p_tx_return;
        en_s && tf_s && $fell(tx_s) |=> FLASH_LEVEL_O;
    endproperty
    a_tx_return: assert property (p_tx_return) else $error("flash not restored");

    property p_sel;
        sel_s |=> !SINK_EN_O[3];
    endproperty
    a_sel: assert property (p_sel) else $error("fourth sink active");

    property p_reg_wait;
        $rose(|SINK_EN_O) |-> $past(vok_s) && (REF_LEVEL_O == REF_MAX);
    endproperty
    a_reg_wait: assert property (p_reg_wait) else $error("sinks before regulation");

    property p_timeout_out;
        TIMEOUT_O |-> (SINK_EN_O == SINKS_NONE) && PUMP_EN_O;
    endproperty
    a_timeout_out: assert property (p_timeout_out) else $error("timeout outputs wrong");

    property p_timeout_hold;
        TIMEOUT_O && en_s |=> TIMEOUT_O;
    endproperty
    a_timeout_hold: assert property (p_timeout_hold) else $error("timeout left early");

    property p_tx_freeze;
        en_s && tf_s && tx_s && !TIMEOUT_O |=> $stable(r.to_cnt) && !TIMEOUT_O;
    endproperty
    a_tx_freeze: assert property (p_tx_freeze) else $error("timer ran in override");

    property p_gain_up;
        en_s |=> GAIN_O >= $past(GAIN_O);
    endproperty
    a_gain_up: assert property (p_gain_up) else $error("gain stepped down");

    property p_step_time;
        $past(en_s) && (GAIN_O != $past(GAIN_O)) |-> $past(r.step_cnt) == $past(step_lim);
    endproperty
    a_step_time: assert property (p_step_time) else $error("gain step early");

    property p_gain_reset;
        !en_s |=> GAIN_O == GAIN_1X;
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("gain not reset");

    property p_soft_start;
        $rose(PUMP_EN_O) |-> REF_LEVEL_O == '0 ##1 REF_LEVEL_O <= 8'h01;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("reference jumped");

    c_run: cover property ($rose(|SINK_EN_O));
    c_timeout: cover property ($rose(TIMEOUT_O));
    c_tx_flash: cover property (FLASH_LEVEL_O ##1 tx_s ##2 !FLASH_LEVEL_O);
    c_gain_2x: cover property (GAIN_O == GAIN_2X);
endmodule
`default_nettype wire

// ==== bench/ftc_host_model.sv ====
// Model of the host control lines and the RF amplifier transmit line.
// Assumes level commands from the bench; pins change on the clock edge.
`timescale 1ns/1ps
`default_nettype none
module ftc_host_model (
    // Clock and supply state
    input  wire logic       clk_i,
    input  wire logic       supply_on_i,
    // Commanded levels: enable, flash, transmit, sink select
    input  wire logic [3:0] cmd_i,
    // Control pins
    output logic            en_o,
    output logic            tf_o,
    output logic            tx_o,
    output logic            sel_o
);
    // Enable is raised only once the supply is up; all pins high = on
    always_ff @(posedge clk_i)
    begin
        en_o  <= cmd_i[3] & supply_on_i;
        tf_o  <= cmd_i[2];
        tx_o  <= cmd_i[1];
        sel_o <= cmd_i[0];
    end
endmodule
`default_nettype wire

// ==== bench/ftc_ctrl_tb.sv ====
// Self-checking bench for the flash/torch mode control block.
// Assumes shortened counts, 20 MHz clock and an APB master in the bench.
`timescale 1ns/1ps
`default_nettype none
module ftc_ctrl_tb;
    import ftc_pkg::*;
    localparam int unsigned TO_C = 200;
    localparam int unsigned TS_C = 50;
    localparam int unsigned FS_C = 10;
    // Clock, reset, supply and pin commands
    logic        mclk;
    logic        rst_n     = 1'b0;
    logic        supply_on = 1'b0;
    logic [3:0]  cmd       = 4'h0;
    logic        en, tf, tx, sel;
    logic        vout_ok   = 1'b0;
    logic        gain_req  = 1'b0;
    // APB master
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [3:0]  pstrb     = 4'hF;
    logic [31:0] prdata;
    logic        pready, pslverr;
    // Analog control outputs
    logic        pump_en, out_con, flash_lvl, tmo;
    logic [7:0]  ref_lvl;
    logic [1:0]  gain;
    logic [3:0]  sink_en;
    int          fail_count      = 0;
    int          samples_checked = 0;

    ftc_host_model host (.clk_i(mclk), .supply_on_i(supply_on), .cmd_i(cmd),
        .en_o(en), .tf_o(tf), .tx_o(tx), .sel_o(sel));

    ftc_ctrl #(.TIMEOUT_CYCLES(TO_C), .TORCH_STEP_CYCLES(TS_C),
        .FLASH_STEP_CYCLES(FS_C)) dut (
        .MCLK_I(mclk), .RESETN_I(rst_n), .EN_I(en), .TORCH_FLASH_I(tf),
        .TX_OVERRIDE_I(tx), .SINK_SEL_I(sel), .VOUT_OK_I(vout_ok),
        .GAIN_UP_REQ_I(gain_req), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .PUMP_EN_O(pump_en), .OUT_CONNECT_O(out_con), .REF_LEVEL_O(ref_lvl),
        .GAIN_O(gain), .SINK_EN_O(sink_en), .FLASH_LEVEL_O(flash_lvl),
        .TIMEOUT_O(tmo));

    // Free-running clock, 50 ns period
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask

    task automatic wrap_up();
        $display("Mismatches %0d in %0d checks", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One APB transfer: setup, then access held until pready at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Set the commanded pin levels, then let n edges pass
    task automatic pins(input logic [3:0] c, input int n);
        cmd <= c;
        repeat (n) @(posedge mclk);
    endtask

    // Count edges until the gain reaches g and judge the interval
    task automatic gain_step(input logic [1:0] g, input int lo, input int hi);
        int n;
        n = 0;
        while (gain !== g && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        chk("gain", g, gain);
        chk("step_min", 1, n >= lo);
        chk("step_max", 1, n <= hi);
    endtask

    // Reset values and register access, unmapped address included
    task automatic s_reset();
        logic [31:0] rd;
        logic        er;
        supply_on <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("pump_rst", 0, pump_en);
        chk("sink_rst", 0, sink_en);
        rst_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0000_0000, rd, er);
        chk("ctrl_rst", 32'h0000_0014, rd);
        apb(1'b0, 8'h0C, 32'h0000_0000, rd, er);
        chk("unmapped_err", 1, er);
        chk("unmapped_rd", 0, rd);
        chk("pready", 1, pready);
        apb(1'b1, REG_CTRL, 32'h0000_0000, rd, er);
        apb(1'b0, REG_CTRL, 32'h0000_0000, rd, er);
        chk("ctrl_wr", 0, rd);
    endtask

    // Start-up: pump first, reference ramp, sinks wait for regulation
    task automatic s_start();
        logic [31:0] rd;
        logic        er;
        pins(4'h8, 6);
        chk("pump_on", 1, pump_en);
        chk("out_con", 1, out_con);
        chk("ref_ramping", 1, ref_lvl < 8'hFF);
        pins(4'h8, 300);
        chk("ref_top", 8'hFF, ref_lvl);
        chk("sink_wait", 0, sink_en);
        vout_ok <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("sink_on", 4'hF, sink_en);
        apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
        chk("status_sink", 4'hF, rd[19:16]);
    endtask

    // Every enabled pin combination, then transmit falling during flash
    task automatic s_modes();
        logic [2:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:0];
            pins({1'b1, m}, 6);
            chk("sinks", m[0] ? 4'h7 : 4'hF, sink_en);
            chk("flash", m[2] & ~m[1], flash_lvl);
        end
        pins(4'hE, 6);
        pins(4'hC, 6);
        chk("flash_back", 1, flash_lvl);
        pins(4'h8, 6);
    endtask

    // Flash timeout, frozen by transmit, cleared only by enable low
    task automatic s_timeout();
        pins(4'hC, 150);
        chk("to_early", 0, tmo);
        pins(4'hE, 150);
        chk("to_frozen", 0, tmo);
        pins(4'hC, 80);
        chk("to_trip", 1, tmo);
        chk("to_sinks", 0, sink_en);
        chk("to_pump", 1, pump_en);
        pins(4'h8, 6);
        chk("to_held", 1, tmo);
        chk("to_held_sink", 0, sink_en);
        pins(4'h0, 6);
        chk("sd_pump", 0, pump_en);
        chk("sd_out", 0, out_con);
        chk("sd_sink", 0, sink_en);
        chk("sd_to", 0, tmo);
        pins(4'h8, 300);
        chk("re_sink", 4'hF, sink_en);
    endtask

    // Gain steps up only, torch and flash step times, reset on shutdown
    task automatic s_gain();
        gain_req <= 1'b1;
        gain_step(GAIN_15X, TS_C, TS_C + 8);
        gain_step(GAIN_2X, TS_C, TS_C + 8);
        repeat (120) @(posedge mclk);
        chk("gain_max", GAIN_2X, gain);
        gain_req <= 1'b0;
        repeat (20) @(posedge mclk);
        chk("gain_kept", GAIN_2X, gain);
        pins(4'h0, 6);
        chk("gain_sd", GAIN_1X, gain);
        pins(4'h8, 300);
        pins(4'hC, 6);
        gain_req <= 1'b1;
        gain_step(GAIN_15X, FS_C, FS_C + 8);
        gain_req <= 1'b0;
        pins(4'h8, 6);
    endtask

    // Cut a hang short
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("[FAIL] run limit expected done seen hang");
        wrap_up();
    end

    initial
    begin
        s_reset();
        s_start();
        s_modes();
        s_timeout();
        s_gain();
        wrap_up();
    end
endmodule
`default_nettype wire
